// file: rtl/tcs_byte_counter.sv
// one 8-bit counting byte with software load and overflow reload
`timescale 1ns/1ps
`include "tcs_map.svh"
module tcs_byte_counter
  import tcs_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_inc,
  input wire logic i_reload_on_wrap,
  input wire logic i_wr,
  input wire tcs_byte_t i_wdata,
  input wire tcs_byte_t i_reload_val,
  output tcs_byte_t o_count,
  output logic o_ovf
);
  tcs_byte_t count_d;

  // wrap happens on the increment that leaves 0xff
  assign o_ovf = i_inc && (o_count == 8'hff);

  // a software write takes priority over counting in the same cycle
  always_comb
  begin
    if (i_wr)
      count_d = i_wdata;
    else if (o_ovf && i_reload_on_wrap)
      count_d = i_reload_val;
    else if (i_inc)
      count_d = o_count + 8'h01;
    else
      count_d = o_count;
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      o_count <= `TCS_RST_BYTE;
    else
      o_count <= count_d;
  end
endmodule

// file: rtl/tcs_map.svh
// register offsets, field positions, reset values and divider counts
`ifndef TCS_MAP_SVH
`define TCS_MAP_SVH

`define TCS_ADDR_CLK_SEL 8'h8e
`define TCS_ADDR_CTRL 8'hc8
`define TCS_ADDR_RELOAD_LO 8'hca
`define TCS_ADDR_RELOAD_HI 8'hcb
`define TCS_ADDR_COUNT_LO 8'hcc
`define TCS_ADDR_COUNT_HI 8'hcd

`define TCS_RST_CLK_SEL 8'h00
`define TCS_RST_CTRL 8'h00
`define TCS_RST_BYTE 8'h00

`define TCS_CS_HI_FAST 6
`define TCS_CS_LO_FAST 5
`define TCS_CS_T1_FAST 4
`define TCS_CS_T0_FAST 3
`define TCS_CS_SCA_HI 1
`define TCS_CS_SCA_LO 0
`define TCS_CS_WMASK 8'h7b

`define TCS_CT_HI_FLAG 7
`define TCS_CT_LO_FLAG 6
`define TCS_CT_LO_IEN 5
`define TCS_CT_SPLIT 3
`define TCS_CT_RUN 2
`define TCS_CT_XCLK 0
`define TCS_CT_WMASK 8'hed

`define TCS_DIV12_LAST 4'hb
`define TCS_DIV4_PHASE 2'h3
`define TCS_DIV48_LAST 2'h3
`define TCS_EXT_DIV_LAST 3'h7

`endif

// file: rtl/tcs_pkg.sv
// types shared by the timer clock select block
package tcs_pkg;
  typedef logic [7:0] tcs_byte_t;
  typedef enum logic [1:0] {
    TCS_PRE_DIV12 = 2'h0,
    TCS_PRE_DIV4 = 2'h1,
    TCS_PRE_DIV48 = 2'h2,
    TCS_PRE_EXT8 = 2'h3
  } tcs_prescale_t;
endpackage

// file: rtl/tcs_prescaler.sv
// tick generator: system clock /4, /12, /48 and external clock /8
`timescale 1ns/1ps
`include "tcs_map.svh"
module tcs_prescaler
  import tcs_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_ext_clk,
  output logic o_div4,
  output logic o_div12,
  output logic o_div48,
  output logic o_ext8
);
  logic [3:0] c12_q, c12_d;
  logic [1:0] c48_q, c48_d;
  logic [2:0] c8_q, c8_d;
  logic sync1_q, sync2_q, prev_q;
  logic div4_d, div12_d, div48_d, ext8_d;
  logic ext_rise;

  // external pin: two flops, then edge compare on the second and a third
  assign ext_rise = sync2_q & ~prev_q;

  // one shared mod-12 counter, so /4 and /48 stay phase locked to /12
  always_comb
  begin
    c12_d = (c12_q == `TCS_DIV12_LAST) ? 4'h0 : c12_q + 4'h1;
    c48_d = (c12_q == `TCS_DIV12_LAST) ? c48_q + 2'h1 : c48_q;
    c8_d = ext_rise ? c8_q + 3'h1 : c8_q;
    div4_d = (c12_q[1:0] == `TCS_DIV4_PHASE);
    div12_d = (c12_q == `TCS_DIV12_LAST);
    div48_d = div12_d && (c48_q == `TCS_DIV48_LAST);
    ext8_d = ext_rise && (c8_q == `TCS_EXT_DIV_LAST);
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      c12_q <= 4'h0;
      c48_q <= 2'h0;
      c8_q <= 3'h0;
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q <= 1'b0;
      o_div4 <= 1'b0;
      o_div12 <= 1'b0;
      o_div48 <= 1'b0;
      o_ext8 <= 1'b0;
    end
    else
    begin
      c12_q <= c12_d;
      c48_q <= c48_d;
      c8_q <= c8_d;
      sync1_q <= i_ext_clk;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
      o_div4 <= div4_d;
      o_div12 <= div12_d;
      o_div48 <= div48_d;
      o_ext8 <= ext8_d;
    end
  end

  a_div12_period: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    o_div12 |=> (!o_div12)[*8] ##1 !o_div12 ##1 !o_div12 ##1 !o_div12
    ##1 o_div12)
    else $error("divide by 12 tick period wrong");
endmodule

// file: rtl/tcs_timer_clock_select.sv
// timer clock select register and the 16-bit / split 8-bit reload timer
`timescale 1ns/1ps
`include "tcs_map.svh"
module tcs_timer_clock_select
  import tcs_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_ext_clk,
  input wire logic [7:0] i_sfr_addr,
  input wire tcs_byte_t i_sfr_wdata,
  input wire logic i_sfr_wr,
  input wire logic i_reload_timer_irq_enable,
  input wire logic i_timer0_counter_mode,
  input wire logic i_timer1_counter_mode,
  output tcs_byte_t o_sfr_rdata,
  output logic o_reload_timer_irq,
  output logic o_timer0_tick,
  output logic o_timer1_tick
);
  tcs_byte_t clk_sel_q, clk_sel_d;
  tcs_byte_t ctrl_q, ctrl_d;
  tcs_byte_t reload_lo_q, reload_lo_d;
  tcs_byte_t reload_hi_q, reload_hi_d;
  tcs_byte_t rdata_d;
  tcs_byte_t count_lo, count_hi;
  tcs_prescale_t pre_sel;
  logic irq_d, t0_tick_d, t1_tick_d;
  logic div4, div12, div48, ext8;
  logic slow_tick, pre_tick, lo_tick, hi_tick;
  logic lo_inc, hi_inc, lo_ovf, hi_ovf, lo_reload;
  logic wr_cs, wr_ct, wr_rll, wr_rlh, wr_tl, wr_th;
  logic split_mode_enable, reload_timer_run, external_clock_select;
  logic high_byte_overflow_flag, low_byte_overflow_flag;
  logic low_byte_interrupt_enable;
  logic t2_high_byte_fast_clock_sel, t2_low_byte_fast_clock_sel;
  logic timer1_fast_clock_sel, timer0_fast_clock_sel;

  // field views of the two control registers
  assign split_mode_enable = ctrl_q[`TCS_CT_SPLIT];
  assign reload_timer_run = ctrl_q[`TCS_CT_RUN];
  assign external_clock_select = ctrl_q[`TCS_CT_XCLK];
  assign high_byte_overflow_flag = ctrl_q[`TCS_CT_HI_FLAG];
  assign low_byte_overflow_flag = ctrl_q[`TCS_CT_LO_FLAG];
  assign low_byte_interrupt_enable = ctrl_q[`TCS_CT_LO_IEN];
  assign t2_high_byte_fast_clock_sel = clk_sel_q[`TCS_CS_HI_FAST];
  assign t2_low_byte_fast_clock_sel = clk_sel_q[`TCS_CS_LO_FAST];
  assign timer1_fast_clock_sel = clk_sel_q[`TCS_CS_T1_FAST];
  assign timer0_fast_clock_sel = clk_sel_q[`TCS_CS_T0_FAST];
  assign pre_sel = tcs_prescale_t'(
    clk_sel_q[`TCS_CS_SCA_HI:`TCS_CS_SCA_LO]);

  // register write decode, one strobe per register
  assign wr_cs = i_sfr_wr && (i_sfr_addr == `TCS_ADDR_CLK_SEL);
  assign wr_ct = i_sfr_wr && (i_sfr_addr == `TCS_ADDR_CTRL);
  assign wr_rll = i_sfr_wr && (i_sfr_addr == `TCS_ADDR_RELOAD_LO);
  assign wr_rlh = i_sfr_wr && (i_sfr_addr == `TCS_ADDR_RELOAD_HI);
  assign wr_tl = i_sfr_wr && (i_sfr_addr == `TCS_ADDR_COUNT_LO);
  assign wr_th = i_sfr_wr && (i_sfr_addr == `TCS_ADDR_COUNT_HI);

  tcs_prescaler u_prescaler (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_ext_clk(i_ext_clk),
    .o_div4(div4),
    .o_div12(div12),
    .o_div48(div48),
    .o_ext8(ext8)
  );

  // slow source for the reload timer bytes
  assign slow_tick = external_clock_select ? ext8 : div12;
  // fast select gives a tick every system clock
  assign lo_tick = t2_low_byte_fast_clock_sel ? 1'b1 : slow_tick;
  assign hi_tick = t2_high_byte_fast_clock_sel ? 1'b1 : slow_tick;

  // low byte runs freely in split mode, gated by run in 16-bit mode
  assign lo_inc = lo_tick && (split_mode_enable || reload_timer_run);
  // 16-bit: high byte steps on low carry, own clock select unused
  assign hi_inc = split_mode_enable ? (hi_tick && reload_timer_run)
                                    : lo_ovf;
  // in 16-bit mode the low byte reloads only on the full rollover
  assign lo_reload = split_mode_enable || (count_hi == 8'hff);

  // the two separately addressable count bytes
  tcs_byte_counter u_count_lo (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_inc(lo_inc),
    .i_reload_on_wrap(lo_reload),
    .i_wr(wr_tl),
    .i_wdata(i_sfr_wdata),
    .i_reload_val(reload_lo_q),
    .o_count(count_lo),
    .o_ovf(lo_ovf)
  );

  tcs_byte_counter u_count_hi (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_inc(hi_inc),
    .i_reload_on_wrap(1'b1),
    .i_wr(wr_th),
    .i_wdata(i_sfr_wdata),
    .i_reload_val(reload_hi_q),
    .o_count(count_hi),
    .o_ovf(hi_ovf)
  );

  // prescaled clock shared by timer 0 and timer 1
  always_comb
  begin
    case (pre_sel)
      TCS_PRE_DIV12: pre_tick = div12;
      TCS_PRE_DIV4: pre_tick = div4;
      TCS_PRE_DIV48: pre_tick = div48;
      TCS_PRE_EXT8: pre_tick = ext8;
      default: pre_tick = div12;
    endcase
  end

  // register next values; a hardware flag set beats a software clear
  always_comb
  begin
    clk_sel_d = clk_sel_q;
    ctrl_d = ctrl_q;
    reload_lo_d = wr_rll ? i_sfr_wdata : reload_lo_q;
    reload_hi_d = wr_rlh ? i_sfr_wdata : reload_hi_q;
    if (wr_cs)
      clk_sel_d = i_sfr_wdata & `TCS_CS_WMASK;
    if (wr_ct)
      ctrl_d = i_sfr_wdata & `TCS_CT_WMASK;
    if (hi_ovf)
      ctrl_d[`TCS_CT_HI_FLAG] = 1'b1;
    if (lo_ovf)
      ctrl_d[`TCS_CT_LO_FLAG] = 1'b1;
  end

  // interrupt request and timer 0/1 clock ticks
  always_comb
  begin
    // flags stay up until software clears them, so this is a level
    irq_d = i_reload_timer_irq_enable &&
            (high_byte_overflow_flag ||
             (low_byte_interrupt_enable && low_byte_overflow_flag));
    // pin counting mode makes the fast select irrelevant
    t0_tick_d = !i_timer0_counter_mode &&
                (timer0_fast_clock_sel || pre_tick);
    t1_tick_d = !i_timer1_counter_mode &&
                (timer1_fast_clock_sel || pre_tick);
  end

  // read mux, one cycle of latency; unmapped addresses read zero
  always_comb
  begin
    case (i_sfr_addr)
      `TCS_ADDR_CLK_SEL: rdata_d = clk_sel_q;
      `TCS_ADDR_CTRL: rdata_d = ctrl_q;
      `TCS_ADDR_RELOAD_LO: rdata_d = reload_lo_q;
      `TCS_ADDR_RELOAD_HI: rdata_d = reload_hi_q;
      `TCS_ADDR_COUNT_LO: rdata_d = count_lo;
      `TCS_ADDR_COUNT_HI: rdata_d = count_hi;
      default: rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      clk_sel_q <= `TCS_RST_CLK_SEL;
      ctrl_q <= `TCS_RST_CTRL;
      reload_lo_q <= `TCS_RST_BYTE;
      reload_hi_q <= `TCS_RST_BYTE;
      o_sfr_rdata <= 8'h00;
      o_reload_timer_irq <= 1'b0;
      o_timer0_tick <= 1'b0;
      o_timer1_tick <= 1'b0;
    end
    else
    begin
      clk_sel_q <= clk_sel_d;
      ctrl_q <= ctrl_d;
      reload_lo_q <= reload_lo_d;
      reload_hi_q <= reload_hi_d;
      o_sfr_rdata <= rdata_d;
      o_reload_timer_irq <= irq_d;
      o_timer0_tick <= t0_tick_d;
      o_timer1_tick <= t1_tick_d;
    end
  end

  // checks kept next to the logic they guard; bus writes are left out
  // where software may legally override the counting in that cycle

  sequence s_full_rollover;
    !split_mode_enable && hi_ovf && !wr_tl && !wr_th;
  endsequence

  sequence s_reload_loaded;
    count_lo == $past(reload_lo_q) && count_hi == $past(reload_hi_q);
  endsequence

  sequence s_low_only_wrap;
    !split_mode_enable && lo_ovf && count_hi != 8'hff && !wr_tl && !wr_th;
  endsequence

  sequence s_carry_taken;
    count_lo == 8'h00 && count_hi == $past(count_hi) + 8'h01;
  endsequence

  // 16-bit mode
  a_reload_sixteen: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    s_full_rollover |=> s_reload_loaded)
    else $error("16-bit rollover did not load reload value");

  a_low_carry: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    s_low_only_wrap |=> s_carry_taken)
    else $error("low wrap did not carry into the high byte");

  a_lo_held_16: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    !split_mode_enable && !reload_timer_run && !wr_tl
    |=> $stable(count_lo))
    else $error("low byte moved while 16-bit timer stopped");

  // flags and interrupt request
  a_hi_flag_set: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    hi_ovf |=> high_byte_overflow_flag)
    else $error("high overflow flag not set");

  a_lo_flag_set: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    lo_ovf |=> low_byte_overflow_flag)
    else $error("low overflow flag not set");

  a_flag_sticky: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    high_byte_overflow_flag && !wr_ct |=> high_byte_overflow_flag)
    else $error("overflow flag cleared without a write");

  a_irq_on_high: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    i_reload_timer_irq_enable && hi_ovf
    |=> ##1 o_reload_timer_irq)
    else $error("no interrupt after high overflow");

  // a control write in the wrap cycle may drop the low enable, so skip it
  a_irq_on_low: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    i_reload_timer_irq_enable && low_byte_interrupt_enable && lo_ovf
    && !wr_ct |=> ##1 o_reload_timer_irq)
    else $error("no interrupt after low overflow");

  a_irq_low_gated: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    !i_reload_timer_irq_enable
    || (!high_byte_overflow_flag && !low_byte_interrupt_enable)
    |=> !o_reload_timer_irq)
    else $error("interrupt raised without cause");

  // split mode
  a_split_lo_runs: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    split_mode_enable && !reload_timer_run && t2_low_byte_fast_clock_sel
    && !wr_tl && !wr_cs && !wr_ct && count_lo != 8'hff
    |=> count_lo == $past(count_lo) + 8'h01)
    else $error("low byte stopped in split mode");

  a_slow_lo_gate: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    split_mode_enable && !t2_low_byte_fast_clock_sel && !slow_tick && !wr_tl
    |=> $stable(count_lo))
    else $error("low byte stepped without a slow tick");

  a_hi_held_stopped: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    split_mode_enable && !reload_timer_run && !wr_th && !wr_ct
    |=> $stable(count_hi))
    else $error("high byte moved while stopped");

  a_hi_fast_split: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    split_mode_enable && reload_timer_run && t2_high_byte_fast_clock_sel
    && !wr_th && count_hi != 8'hff
    |=> count_hi == $past(count_hi) + 8'h01)
    else $error("high byte not on system clock in split mode");

  a_split_reload_lo: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    split_mode_enable && lo_ovf && !wr_tl |=> count_lo == $past(reload_lo_q))
    else $error("split low byte did not reload");

  a_split_reload_hi: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    split_mode_enable && hi_ovf && !wr_th |=> count_hi == $past(reload_hi_q))
    else $error("split high byte did not reload");

  // clock select register and timer 0/1 ticks
  a_unused_zero: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    i_sfr_addr == `TCS_ADDR_CLK_SEL |=> !o_sfr_rdata[7] && !o_sfr_rdata[2])
    else $error("unused clock select bit reads one");

  a_t0_pin_mode: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    i_timer0_counter_mode |=> !o_timer0_tick)
    else $error("timer 0 tick while counting pin");

  a_t1_pin_mode: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    i_timer1_counter_mode |=> !o_timer1_tick)
    else $error("timer 1 tick while counting pin");

  a_t0_fast_tick: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    !i_timer0_counter_mode && timer0_fast_clock_sel |=> o_timer0_tick)
    else $error("timer 0 missing a fast tick");
endmodule

// file: tb/tcs_timer_clock_select_test.sv
// self-checking bench for the timer clock select block and reload timer
`timescale 1ns/1ps
`include "tcs_map.svh"
module tcs_timer_clock_select_test
  import tcs_pkg::*;
;
  logic i_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic ext_clk = 1'b0;
  logic [7:0] addr = 8'h00;
  tcs_byte_t wdata = 8'h00;
  logic wr = 1'b0;
  logic irq_en = 1'b0;
  logic t0_cnt = 1'b0;
  logic t1_cnt = 1'b0;
  tcs_byte_t rdata;
  logic irq;
  logic tick0;
  logic tick1;
  int bad_count = 0;
  int check_count = 0;
  tcs_byte_t v;
  int n0;
  int n1;
  // clock-source cases: select, control, byte, wait, lowest, highest
  localparam logic [7:0] C_SEL [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h40,
    8'h40};
  localparam logic [7:0] C_CT [6] = '{8'h08, 8'h09, 8'h0c, 8'h0d, 8'h04,
    8'h0c};
  localparam logic [7:0] C_AD [6] = '{8'hcc, 8'hcc, 8'hcd, 8'hcd, 8'hcc,
    8'hcd};
  localparam int C_N [6] = '{120, 640, 120, 640, 120, 120};
  localparam int C_LO [6] = '{9, 8, 9, 8, 9, 118};
  localparam int C_HI [6] = '{11, 11, 11, 11, 11, 124};
  // prescaled tick counts over 480 cycles for the four prescale codes
  localparam int P_LO [4] = '{39, 119, 9, 6};
  localparam int P_HI [4] = '{41, 121, 11, 9};

  // 200 MHz system clock; external oscillator at one eighth of that
  always #2.5 i_clk = ~i_clk;
  always #20 ext_clk = ~ext_clk;

  tcs_timer_clock_select dut (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_ext_clk(ext_clk),
    .i_sfr_addr(addr),
    .i_sfr_wdata(wdata),
    .i_sfr_wr(wr),
    .i_reload_timer_irq_enable(irq_en),
    .i_timer0_counter_mode(t0_cnt),
    .i_timer1_counter_mode(t1_cnt),
    .o_sfr_rdata(rdata),
    .o_reload_timer_irq(irq),
    .o_timer0_tick(tick0),
    .o_timer1_tick(tick1)
  );

  task automatic report_and_stop();
    if (bad_count == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(string nm, logic [7:0] exp, logic [7:0] got);
    check_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask

  // range compare for counts whose exact phase is not pinned down
  task automatic rng(string nm, int lo, int hi, logic [15:0] got);
    check_count++;
    if ((^got === 1'bx) || got < lo || got > hi)
    begin
      bad_count++;
      $display("[ERR] %s exp %0d..%0d got %0d", nm, lo, hi, got);
    end
  endtask

  // one write: strobe for exactly one edge
  task automatic wr_reg(logic [7:0] a, tcs_byte_t d);
    @(posedge i_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge i_clk);
    wr <= 1'b0;
  endtask

  // read data is registered one edge after the address is seen
  task automatic rd(logic [7:0] a, output tcs_byte_t d);
    @(posedge i_clk);
    addr <= a;
    @(posedge i_clk);
    #1;
    d = rdata;
  endtask

  task automatic rchk(string nm, logic [7:0] a, tcs_byte_t exp);
    tcs_byte_t d;
    rd(a, d);
    chk(nm, exp, d);
  endtask

  // the irq is a registered level, so give it two edges to follow a change
  task automatic ichk(logic exp);
    repeat (2) @(posedge i_clk);
    #1;
    chk("irq", {7'h00, exp}, {7'h00, irq});
  endtask

  task automatic ticks();
    n0 = 0;
    n1 = 0;
    repeat (20) @(posedge i_clk);
    repeat (480)
    begin
      @(posedge i_clk);
      #1;
      if (tick0 === 1'b1) n0++;
      if (tick1 === 1'b1) n1++;
    end
  endtask

  // watchdog: the whole sequence needs well under 10000 cycles
  initial
  begin
    #200000;
    bad_count++;
    report_and_stop();
  end

  initial
  begin
    repeat (2) @(posedge i_clk);
    i_rstn <= 1'b1;
    repeat (4) @(posedge i_clk);
    // reset values and masked bits
    rchk("clk_sel rst", `TCS_ADDR_CLK_SEL, 8'h00);
    rchk("ctrl rst", `TCS_ADDR_CTRL, 8'h00);
    rchk("cnt lo rst", `TCS_ADDR_COUNT_LO, 8'h00);
    wr_reg(`TCS_ADDR_CLK_SEL, 8'hff);
    rchk("clk_sel mask", `TCS_ADDR_CLK_SEL, 8'h7b);
    wr_reg(`TCS_ADDR_CTRL, 8'hff);
    rchk("ctrl mask", `TCS_ADDR_CTRL, 8'hed);
    wr_reg(`TCS_ADDR_CTRL, 8'h00);
    wr_reg(8'h00, 8'hff);
    rchk("unmapped", 8'h00, 8'h00);
    // 16-bit rollover reloads both bytes and sets the high flag
    @(posedge i_clk) irq_en <= 1'b1;
    wr_reg(`TCS_ADDR_CLK_SEL, 8'h20);
    wr_reg(`TCS_ADDR_RELOAD_LO, 8'h34);
    wr_reg(`TCS_ADDR_RELOAD_HI, 8'h12);
    wr_reg(`TCS_ADDR_COUNT_LO, 8'hfe);
    wr_reg(`TCS_ADDR_COUNT_HI, 8'hff);
    wr_reg(`TCS_ADDR_CTRL, 8'h04);
    repeat (10) @(posedge i_clk);
    rchk("cnt hi reload", `TCS_ADDR_COUNT_HI, 8'h12);
    // the low byte wraps together with the high byte, so its flag rises too
    rchk("hi flag", `TCS_ADDR_CTRL, 8'hc4);
    ichk(1'b1);
    @(posedge i_clk) irq_en <= 1'b0;
    ichk(1'b0);
    @(posedge i_clk) irq_en <= 1'b1;
    wr_reg(`TCS_ADDR_CTRL, 8'h80);
    rd(`TCS_ADDR_COUNT_LO, v);
    rng("cnt lo run", 8'h34, 8'h50, {8'h00, v});
    repeat (60) @(posedge i_clk);
    rchk("cnt lo stop", `TCS_ADDR_COUNT_LO, v);
    rchk("hi flag kept", `TCS_ADDR_CTRL, 8'h80);
    wr_reg(`TCS_ADDR_CTRL, 8'h00);
    rchk("flag cleared", `TCS_ADDR_CTRL, 8'h00);
    ichk(1'b0);
    // low byte wrap in 16-bit mode carries into the high byte
    wr_reg(`TCS_ADDR_COUNT_LO, 8'hf0);
    wr_reg(`TCS_ADDR_COUNT_HI, 8'h00);
    wr_reg(`TCS_ADDR_CTRL, 8'h24);
    repeat (30) @(posedge i_clk);
    rchk("carry", `TCS_ADDR_COUNT_HI, 8'h01);
    rchk("lo flag", `TCS_ADDR_CTRL, 8'h64);
    ichk(1'b1);
    wr_reg(`TCS_ADDR_CTRL, 8'h44);
    ichk(1'b0);
    wr_reg(`TCS_ADDR_CTRL, 8'h00);
    // split mode: low byte free-running, high byte held by run bit
    wr_reg(`TCS_ADDR_CLK_SEL, 8'h60);
    wr_reg(`TCS_ADDR_RELOAD_LO, 8'h80);
    wr_reg(`TCS_ADDR_RELOAD_HI, 8'h00);
    wr_reg(`TCS_ADDR_COUNT_LO, 8'hf0);
    wr_reg(`TCS_ADDR_COUNT_HI, 8'h10);
    wr_reg(`TCS_ADDR_CTRL, 8'h08);
    repeat (30) @(posedge i_clk);
    rd(`TCS_ADDR_COUNT_LO, v);
    rng("split lo reload", 8'h80, 8'h9f, {8'h00, v});
    rchk("split hi held", `TCS_ADDR_COUNT_HI, 8'h10);
    rchk("split lo flag", `TCS_ADDR_CTRL, 8'h48);
    ichk(1'b0);
    wr_reg(`TCS_ADDR_CTRL, 8'h68);
    ichk(1'b1);
    wr_reg(`TCS_ADDR_COUNT_HI, 8'hf0);
    wr_reg(`TCS_ADDR_CTRL, 8'h0c);
    repeat (30) @(posedge i_clk);
    rd(`TCS_ADDR_COUNT_HI, v);
    rng("split hi reload", 8'h00, 8'h1f, {8'h00, v});
    rd(`TCS_ADDR_CTRL, v);
    chk("split hi flag", 8'h80, v & 8'h80);
    ichk(1'b1);
    wr_reg(`TCS_ADDR_CTRL, 8'h00);
    // clock sources of each byte in split mode and of the low byte in 16-bit mode
    for (int i = 0; i < 6; i++)
    begin
      wr_reg(`TCS_ADDR_CTRL, 8'h00);
      wr_reg(`TCS_ADDR_CLK_SEL, C_SEL[i]);
      wr_reg(`TCS_ADDR_COUNT_LO, 8'h00);
      wr_reg(`TCS_ADDR_COUNT_HI, 8'h00);
      wr_reg(`TCS_ADDR_CTRL, C_CT[i]);
      repeat (C_N[i]) @(posedge i_clk);
      rd(C_AD[i], v);
      rng("clk src", C_LO[i], C_HI[i], 16'(v));
    end
    wr_reg(`TCS_ADDR_CTRL, 8'h00);
    // shared prescaler codes for timers 0 and 1
    for (int p = 0; p < 4; p++)
    begin
      wr_reg(`TCS_ADDR_CLK_SEL, 8'(p));
      ticks();
      rng("t0 prescale", P_LO[p], P_HI[p], 16'(n0));
      rng("t1 prescale", P_LO[p], P_HI[p], 16'(n1));
    end
    wr_reg(`TCS_ADDR_CLK_SEL, 8'h18);
    ticks();
    rng("t0 fast", 480, 480, 16'(n0));
    rng("t1 fast", 480, 480, 16'(n1));
    @(posedge i_clk);
    t0_cnt <= 1'b1;
    t1_cnt <= 1'b1;
    ticks();
    rng("t0 pin mode", 0, 0, 16'(n0));
    rng("t1 pin mode", 0, 0, 16'(n1));
    report_and_stop();
  end
endmodule
